// ===== bringup_pkg.sv
// Package for the link bring-up register bank: offsets, reset values,
// field positions, timing constants and the configuration carriers.
// Assumes 12-bit byte offsets and 8-bit register data on the control port.
package bringup_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [11:0] OFF_SYNC_CTRL = 12'h03A;
   localparam logic [11:0] OFF_SYNC_STAT = 12'h03B;
   localparam logic [11:0] OFF_CDR_RESET = 12'h206;
   localparam logic [11:0] OFF_REC_CLOCK = 12'h230;
   localparam logic [11:0] OFF_EQUALIZER = 12'h268;
   localparam logic [11:0] OFF_PLL_ENABLE = 12'h280;
   localparam logic [11:0] OFF_PLL_LOCK = 12'h281;
   localparam logic [11:0] OFF_PLL_DIVIDER = 12'h289;
   localparam logic [11:0] OFF_LINK_CTRL = 12'h300;
   localparam logic [11:0] OFF_SUBCLASS = 12'h301;
   localparam logic [11:0] OFF_LINK_STAT = 12'h302;
   localparam logic [11:0] OFF_DELAY_LO = 12'h304;
   localparam logic [11:0] OFF_DELAY_HI = 12'h305;
   localparam logic [11:0] OFF_VAR_LO = 12'h306;
   localparam logic [11:0] OFF_VAR_HI = 12'h307;
   localparam logic [11:0] OFF_XBAR0 = 12'h308;
   localparam logic [11:0] OFF_LANE_INV = 12'h334;

   // Every read/write byte of the bank, in storage order
   localparam int NUM_RW = 39;
   localparam logic [11:0] RW_OFFS [NUM_RW] = '{
      OFF_SYNC_CTRL, OFF_CDR_RESET, OFF_REC_CLOCK, OFF_EQUALIZER, OFF_PLL_ENABLE,
      12'h284, 12'h285, 12'h286, 12'h287, OFF_PLL_DIVIDER, 12'h28A, 12'h28B,
      12'h290, 12'h294, 12'h296, 12'h297, 12'h299, 12'h29A, 12'h29C, 12'h29F,
      12'h2A0, 12'h2A7, 12'h2AA, 12'h2AB, 12'h2AE, 12'h2B1, 12'h2B2,
      OFF_LINK_CTRL, OFF_SUBCLASS, OFF_DELAY_LO, OFF_DELAY_HI, OFF_VAR_LO,
      OFF_VAR_HI, OFF_XBAR0, 12'h309, 12'h30A, 12'h30B, 12'h314, OFF_LANE_INV};

   // Reset values; crossbar starts as identity, equalizer byte at 0x22
   localparam logic [7:0] RST_EQUALIZER = 8'h22;
   localparam logic [7:0] RST_XBAR [4] = '{8'h10, 8'h32, 8'h54, 8'h76};

   // Field positions
   localparam int SYNC_EN_BIT = 7;
   localparam int SYNC_ARM_BIT = 6;
   localparam logic [3:0] SYNC_MODE_ONESHOT = 4'h1;
   localparam int SYNC_LOCK_BIT = 3;
   localparam int SYNC_WAIT_BIT = 0;
   localparam int REC_HALF_BIT = 5;
   localparam int REC_OVS_BIT = 1;
   localparam int DIV_CFG_BIT = 2;
   localparam int LINK_SUM_BIT = 6;
   localparam int LINK_TWO_BIT = 3;
   localparam int LINK_STSEL_BIT = 2;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int PLL_LOCK_TIME_NS = 1000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic cdr_run;
      logic half_rate;
      logic recovery_oversample;
      logic [1:0] rx_pll_divider_sel;
      logic pll_enable;
      logic [1:0] equalizer_select;
   } phy_cfg_s;

   typedef struct packed {
      logic [7:0] subclass;
      logic [15:0] frame_clock_delay;
      logic [15:0] frame_clock_variance;
      logic sum_check_sel;
      logic two_link_sel;
      logic [1:0] link_enable_field;
   } link_cfg_s;

   // Storage slot of a read/write offset, -1 when unmapped
   function automatic int idx_of(logic [11:0] a);
      int r;
      r = -1;
      for (int i = 0; i < NUM_RW; i++) begin
         if (RW_OFFS[i] == a) begin
            r = i;
         end
      end
      return r;
   endfunction : idx_of

endpackage : bringup_pkg

// ===== serdes_link_bringup_config.sv
// Link bring-up register bank: physical and data link layer settings,
// receive PLL lock model, one-shot frame clock sync machine, lane crossbar
// and polarity inversion.
// Assumes register accesses and lane words arrive on mclk_i; only the
// alignment pulse pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
`default_nettype none

module serdes_link_bringup_config
   import bringup_pkg::*;
#(
   parameter int LANES = 8,
   parameter int LANE_W = 16
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [bringup_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [bringup_pkg::DATA_W-1:0] reg_wdata_i,
   output logic [bringup_pkg::DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic sysref_i,
   input wire logic [7:0] link0_status_i,
   input wire logic [7:0] link1_status_i,
   input wire logic [LANES*LANE_W-1:0] phys_lane_i,
   output logic [LANES*LANE_W-1:0] logical_lane_o,
   output bringup_pkg::phy_cfg_s phy_cfg_o,
   output bringup_pkg::link_cfg_s link_cfg_o,
   output logic [1:0] link_active_o,
   output logic sync_locked_o
);
   import bringup_pkg::*;

   localparam int I_SYNC = idx_of(OFF_SYNC_CTRL);
   localparam int I_CDR = idx_of(OFF_CDR_RESET);
   localparam int I_REC = idx_of(OFF_REC_CLOCK);
   localparam int I_EQ = idx_of(OFF_EQUALIZER);
   localparam int I_PLLEN = idx_of(OFF_PLL_ENABLE);
   localparam int I_DIV = idx_of(OFF_PLL_DIVIDER);
   localparam int I_LINK = idx_of(OFF_LINK_CTRL);
   localparam int I_SUB = idx_of(OFF_SUBCLASS);
   localparam int I_DLO = idx_of(OFF_DELAY_LO);
   localparam int I_DHI = idx_of(OFF_DELAY_HI);
   localparam int I_VLO = idx_of(OFF_VAR_LO);
   localparam int I_VHI = idx_of(OFF_VAR_HI);
   localparam int I_XB0 = idx_of(OFF_XBAR0);
   localparam int I_INV = idx_of(OFF_LANE_INV);
   localparam int LOCK_W = $clog2(PLL_LOCK_CYCLES + 1);
   localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(PLL_LOCK_CYCLES);

   typedef enum logic [1:0] {
      SYNC_IDLE = 2'b00,
      SYNC_ARMED = 2'b01,
      SYNC_DONE = 2'b11
   } sync_state_e;

   logic [7:0] cfg_r [NUM_RW];
   logic [LOCK_W-1:0] lock_cnt_r;
   logic pll_locked_r;
   logic sysref_meta_r;
   logic sysref_sync_r;
   logic sysref_prev_r;
   logic sysref_edge;
   logic sync_enabled;
   logic arm_write;
   sync_state_e sync_state_r;
   sync_state_e sync_nxt;
   logic sync_lock_r;
   logic [7:0] rd_nxt;

   // Register storage, one slot per read/write byte
   for (genvar g = 0; g < NUM_RW; g++) begin : g_cfg
      localparam logic [7:0] RST_V = (g == I_EQ) ? RST_EQUALIZER :
         (g >= I_XB0 && g < I_XB0 + 4) ? RST_XBAR[(g - I_XB0) & 3] : 8'h00;
      always_ff @(posedge mclk_i or posedge reset_i) begin
         if (reset_i) begin
            cfg_r[g] <= RST_V;
         end else if (reg_wr_i && reg_addr_i == RW_OFFS[g]) begin
            cfg_r[g] <= reg_wdata_i;
         end else if (g == I_SYNC && sync_state_r == SYNC_ARMED && sysref_edge) begin
            // One-shot: the arm bit drops once the edge has been taken
            cfg_r[g][SYNC_ARM_BIT] <= 1'b0;
         end
      end
   end

   // PLL lock model: counts a fixed settle time after the enable is set
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         lock_cnt_r <= '0;
         pll_locked_r <= 1'b0;
      end else if (!cfg_r[I_PLLEN][0]) begin
         lock_cnt_r <= '0;
         pll_locked_r <= 1'b0;
      end else if (lock_cnt_r != LOCK_LAST) begin
         lock_cnt_r <= lock_cnt_r + 1'b1;
      end else begin
         pll_locked_r <= 1'b1;
      end
   end

   // Alignment pulse: two flops, then the edge detector reads the second
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sysref_meta_r <= 1'b0;
         sysref_sync_r <= 1'b0;
         sysref_prev_r <= 1'b0;
      end else begin
         sysref_meta_r <= sysref_i;
         sysref_sync_r <= sysref_meta_r;
         sysref_prev_r <= sysref_sync_r;
      end
   end

   assign sysref_edge = sysref_sync_r && !sysref_prev_r;
   assign sync_enabled = cfg_r[I_SYNC][SYNC_EN_BIT] &&
      cfg_r[I_SYNC][3:0] == SYNC_MODE_ONESHOT;
   assign arm_write = reg_wr_i && reg_addr_i == OFF_SYNC_CTRL &&
      reg_wdata_i[SYNC_ARM_BIT] && reg_wdata_i[SYNC_EN_BIT];

   // Sync machine next state; a fresh arm restarts the search
   always_comb begin
      sync_nxt = sync_state_r;
      case (sync_state_r)
         SYNC_IDLE: begin
            if (sync_enabled && cfg_r[I_SYNC][SYNC_ARM_BIT]) begin
               sync_nxt = SYNC_ARMED;
            end
         end
         SYNC_ARMED: begin
            if (!sync_enabled) begin
               sync_nxt = SYNC_IDLE;
            end else if (sysref_edge) begin
               sync_nxt = SYNC_DONE;
            end
         end
         SYNC_DONE: begin
            if (!sync_enabled || arm_write) begin
               sync_nxt = SYNC_IDLE;
            end
         end
         default: sync_nxt = SYNC_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_state_r <= SYNC_IDLE;
      end else begin
         sync_state_r <= sync_nxt;
      end
   end

   // Sticky lock flag: in SYNC_ARMED, an edge in the same cycle as a re-arm still sets it
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_lock_r <= 1'b0;
      end else if (sync_state_r == SYNC_ARMED && sync_enabled && sysref_edge) begin
         sync_lock_r <= 1'b1;
      end else if (arm_write || !sync_enabled) begin
         sync_lock_r <= 1'b0;
      end
   end

   // Crossbar then polarity inversion, one slice per logical lane
   for (genvar x = 0; x < LANES; x++) begin : g_lane
      logic [2:0] sel;
      logic [LANE_W-1:0] picked;
      assign sel = (x % 2 == 0) ? cfg_r[I_XB0 + (x / 2) % 4][2:0]
                                : cfg_r[I_XB0 + (x / 2) % 4][6:4];
      assign picked = phys_lane_i[(32'(sel) % LANES) * LANE_W +: LANE_W];
      always_ff @(posedge mclk_i or posedge reset_i) begin
         if (reset_i) begin
            logical_lane_o[x*LANE_W +: LANE_W] <= '0;
         end else if (cfg_r[I_INV][x % 8]) begin
            logical_lane_o[x*LANE_W +: LANE_W] <= ~picked;
         end else begin
            logical_lane_o[x*LANE_W +: LANE_W] <= picked;
         end
      end
   end

   // Configuration fields driven straight from storage flops
   always_comb begin
      phy_cfg_o.cdr_run = cfg_r[I_CDR][0];
      phy_cfg_o.half_rate = cfg_r[I_REC][REC_HALF_BIT];
      phy_cfg_o.recovery_oversample = cfg_r[I_REC][REC_OVS_BIT];
      phy_cfg_o.rx_pll_divider_sel = cfg_r[I_DIV][1:0];
      phy_cfg_o.pll_enable = cfg_r[I_PLLEN][0];
      phy_cfg_o.equalizer_select = cfg_r[I_EQ][7:6];
      link_cfg_o.subclass = cfg_r[I_SUB];
      link_cfg_o.frame_clock_delay = {cfg_r[I_DHI], cfg_r[I_DLO]};
      link_cfg_o.frame_clock_variance = {cfg_r[I_VHI], cfg_r[I_VLO]};
      link_cfg_o.sum_check_sel = cfg_r[I_LINK][LINK_SUM_BIT];
      link_cfg_o.two_link_sel = cfg_r[I_LINK][LINK_TWO_BIT];
      link_cfg_o.link_enable_field = cfg_r[I_LINK][1:0];
   end

   // Link 1 can only run in two-link operation, whatever the field holds
   assign link_active_o = cfg_r[I_LINK][1:0] &
      (cfg_r[I_LINK][LINK_TWO_BIT] ? 2'b11 : 2'b01);
   assign sync_locked_o = sync_lock_r;

   // Readback mux; unmapped offsets return zero
   always_comb begin
      rd_nxt = 8'h00;
      for (int i = 0; i < NUM_RW; i++) begin
         if (reg_addr_i == RW_OFFS[i]) begin
            rd_nxt = cfg_r[i];
         end
      end
      if (reg_addr_i == OFF_PLL_LOCK) begin
         rd_nxt = {7'b000_0000, pll_locked_r};
      end else if (reg_addr_i == OFF_SYNC_STAT) begin
         rd_nxt = 8'h00;
         rd_nxt[SYNC_LOCK_BIT] = sync_lock_r;
         rd_nxt[SYNC_WAIT_BIT] = (sync_state_r == SYNC_ARMED);
      end else if (reg_addr_i == OFF_LINK_STAT) begin
         rd_nxt = cfg_r[I_LINK][LINK_STSEL_BIT] ? link1_status_i
                                                : link0_status_i;
      end
   end

   // Read data is registered; valid pulses one cycle after the strobe
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_nxt;
         end
      end
   end

endmodule : serdes_link_bringup_config

`default_nettype wire

// ===== bringup_props.sv
// Checker for the bring-up bank: bus answer, status select, sync lock, link mask.
// Assumes one clock domain and the port names of the bank's top module.
`timescale 1ns/1ps
`default_nettype none
module bringup_props
   import bringup_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic sysref_i,
   input wire logic [7:0] link0_status_i,
   input wire logic [7:0] link1_status_i,
   input wire bringup_pkg::link_cfg_s link_cfg_o,
   input wire logic [1:0] link_active_o,
   input wire logic sync_locked_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   logic sel_r;
   // Mirror of the status select bit, since the bank does not export it
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_r <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == OFF_LINK_CTRL) begin
         sel_r <= reg_wdata_i[LINK_STSEL_BIT];
      end
   end
   a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe not answered next cycle");
   a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read answer without a strobe");
   a_status_sel: assert property (reg_rd_i && reg_addr_i == OFF_LINK_STAT |=>
      reg_rdata_o == (sel_r ? $past(link1_status_i) : $past(link0_status_i)))
      else $error("link status readback from wrong link");
   a_link_mask: assert property (link_active_o == (link_cfg_o.link_enable_field &
      (link_cfg_o.two_link_sel ? 2'b11 : 2'b01))) else $error("link enable mask wrong");
   // Pulse is four cycles wide, so two cycles back it must still be high
   a_lock_cause: assert property ($rose(sync_locked_o) |-> $past(sysref_i, 2))
      else $error("sync lock without an alignment edge");
   a_lock_sticky: assert property (sync_locked_o &&
      !(reg_wr_i && reg_addr_i == OFF_SYNC_CTRL) |=> sync_locked_o)
      else $error("sync lock dropped by itself");
   a_delay_map: assert property (reg_wr_i && reg_addr_i == OFF_DELAY_LO |=>
      link_cfg_o.frame_clock_delay[7:0] == $past(reg_wdata_i))
      else $error("frame delay low byte not taken");
   a_var_map: assert property (reg_wr_i && reg_addr_i == OFF_VAR_HI |=>
      link_cfg_o.frame_clock_variance[15:8] == $past(reg_wdata_i))
      else $error("frame variance high byte not taken");
   c_lock: cover property ($rose(sync_locked_o));
   c_link1: cover property (reg_rd_i && reg_addr_i == OFF_LINK_STAT && sel_r);
   c_two: cover property (link_active_o == 2'b11);
endmodule : bringup_props
`default_nettype wire

// ===== link_tx_model.sv
// Far-end transmitter model: alignment pulses on request and moving lane words.
// Assumes the requester raises fire_i for one cycle, changed on falling edges.
`timescale 1ns/1ps
`default_nettype none
module link_tx_model (
   input wire logic mclk_i,
   input wire logic fire_i,
   output logic sysref_o,
   output logic [127:0] lane_o
);
   int cnt = 0;
   logic [15:0] k = 16'h0001;
   initial begin
      sysref_o = 1'b0;
      lane_o = '0;
   end
   // A request yields a pulse four cycles wide so a two-flop sync sees it
   always @(posedge mclk_i) begin
      cnt <= fire_i ? 4 : (cnt > 0 ? cnt - 1 : 0);
   end
   // Lane words differ per lane and move every cycle, away from the sampling edge
   always @(negedge mclk_i) begin
      sysref_o <= (cnt != 0);
      k <= k + 16'h1357;
      for (int i = 0; i < 8; i++) begin
         lane_o[i*16 +: 16] <= 16'(k * (i + 1) + i);
      end
   end
endmodule : link_tx_model
`default_nettype wire

// ===== serdes_link_bringup_config_tb.sv
// Testbench for the bring-up bank: register map, PLL lock, sync, lanes, links.
// Assumes link_tx_model as far end and bringup_props bound below.
`timescale 1ns/1ps
`default_nettype none
module serdes_link_bringup_config_tb;
   import bringup_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [11:0] reg_addr_i = '0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_wdata_i = '0;
   logic [7:0] link0_status_i = '0;
   logic [7:0] link1_status_i = '0;
   logic [7:0] reg_rdata_o, d;
   logic reg_rvalid_o, sysref_i, sync_locked_o, fire = 1'b0;
   logic [127:0] phys_lane_i, logical_lane_o, p, e;
   logic [1:0] link_active_o;
   phy_cfg_s phy_cfg_o;
   link_cfg_s link_cfg_o;
   logic [7:0] m [logic [11:0]];
   int failures = 0, check_count = 0, cycles = 0, seed = 18338, s;
   always #25 mclk_i = ~mclk_i;
   serdes_link_bringup_config uut (.mclk_i, .reset_i, .reg_addr_i, .reg_wr_i,
      .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .sysref_i,
      .link0_status_i, .link1_status_i, .phys_lane_i, .logical_lane_o,
      .phy_cfg_o, .link_cfg_o, .link_active_o, .sync_locked_o);
   link_tx_model far (.mclk_i, .fire_i(fire), .sysref_o(sysref_i), .lane_o(phys_lane_i));
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(negedge mclk_i);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      @(negedge mclk_i);
      reg_wr_i = 1'b0;
      m[a] = v;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(negedge mclk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge mclk_i);
      reg_rd_i = 1'b0;
      chk(reg_rvalid_o, 1'b1);
      d = reg_rdata_o;
   endtask : rd
   // One alignment request, then time for sync and detection to settle
   task automatic pulse;
      @(negedge mclk_i);
      fire = 1'b1;
      @(negedge mclk_i);
      fire = 1'b0;
      repeat (8) @(negedge mclk_i);
   endtask : pulse
   task automatic summarize;
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(negedge mclk_i);
      reset_i = 1'b0;
      // Reset values, then random write and readback of every byte
      foreach (RW_OFFS[i]) begin
         rd(RW_OFFS[i]);
         s = RW_OFFS[i] - OFF_XBAR0;
         chk(d, RW_OFFS[i] == OFF_EQUALIZER ? 8'h22 : (s >= 0 && s < 4) ? RST_XBAR[s] : 8'h00);
      end
      foreach (RW_OFFS[i]) wr(RW_OFFS[i], 8'($random(seed)));
      foreach (RW_OFFS[i]) begin
         rd(RW_OFFS[i]);
         chk(d, m[RW_OFFS[i]]);
      end
      chk(link_cfg_o.frame_clock_delay, {m[OFF_DELAY_HI], m[OFF_DELAY_LO]});
      chk(link_cfg_o.frame_clock_variance, {m[OFF_VAR_HI], m[OFF_VAR_LO]});
      chk(link_cfg_o.subclass, m[OFF_SUBCLASS]);
      wr(12'h3FF, 8'hA5);
      rd(12'h3FF);
      chk(d, 8'h00);
      // Physical layer bring-up before the PLL is enabled
      wr(OFF_PLL_ENABLE, 8'h00);
      wr(12'h284, 8'h62);
      wr(12'h285, 8'hC9);
      wr(12'h286, 8'h0E);
      wr(12'h287, 8'h12);
      wr(12'h294, 8'h24);
      wr(12'h29C, 8'h2A);
      wr(12'h28A, 8'h7B);
      wr(OFF_REC_CLOCK, 8'h2A);
      wr(OFF_PLL_DIVIDER, 8'h05);
      wr(OFF_EQUALIZER, 8'h62);
      wr(OFF_CDR_RESET, 8'h01);
      chk(phy_cfg_o, {1'b1, 1'b1, 1'b1, 2'b01, 1'b0, 2'b01});
      wr(OFF_PLL_LOCK, 8'hFF);
      wr(OFF_PLL_ENABLE, 8'h01);
      rd(OFF_PLL_LOCK);
      chk(d[0], 1'b0);
      repeat (PLL_LOCK_CYCLES - 3) @(negedge mclk_i);
      rd(OFF_PLL_LOCK);
      chk(d[0], 1'b0);
      rd(OFF_PLL_LOCK);
      chk(d[0], 1'b1);
      // Sync machine: an edge before arming is ignored, one after it locks
      wr(OFF_SYNC_CTRL, 8'h01);
      wr(OFF_SYNC_CTRL, 8'h81);
      pulse();
      rd(OFF_SYNC_STAT);
      chk(d[3], 1'b0);
      wr(OFF_SYNC_CTRL, 8'hC1);
      rd(OFF_SYNC_STAT);
      chk(d[0], 1'b1);
      pulse();
      rd(OFF_SYNC_STAT);
      chk({d[3], sync_locked_o}, 2'b11);
      rd(OFF_SYNC_CTRL);
      chk(d, 8'h81);
      wr(OFF_SYNC_CTRL, 8'hC1);
      rd(OFF_SYNC_STAT);
      chk(d[3], 1'b0);
      // Random crossbar and inversion, checked against the lane model
      for (int n = 0; n < 4; n++) wr(OFF_XBAR0 + 12'(n), 8'($random(seed)) & 8'h77);
      wr(OFF_LANE_INV, 8'($random(seed)));
      repeat (20) begin
         @(posedge mclk_i);
         p = phys_lane_i;
         #10;
         for (int x = 0; x < 8; x++) begin
            s = x[0] ? m[OFF_XBAR0 + 12'(x / 2)][6:4] : m[OFF_XBAR0 + 12'(x / 2)][2:0];
            e[x*16 +: 16] = p[s*16 +: 16] ^ {16{m[OFF_LANE_INV][x]}};
         end
         chk(logical_lane_o, e);
      end
      // Every value of link control bits 3:0: enable mask and status select
      for (int v = 0; v < 16; v++) begin
         link0_status_i = 8'($random(seed));
         link1_status_i = 8'($random(seed));
         wr(OFF_LINK_CTRL, 8'(v));
         chk(link_active_o, 2'(v) & (v[3] ? 2'b11 : 2'b01));
         rd(OFF_LINK_STAT);
         chk(d, v[2] ? link1_status_i : link0_status_i);
      end
      summarize();
   end
endmodule : serdes_link_bringup_config_tb
bind serdes_link_bringup_config bringup_props props (.mclk_i, .reset_i, .reg_addr_i,
   .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .sysref_i,
   .link0_status_i, .link1_status_i, .link_cfg_o, .link_active_o, .sync_locked_o);
`default_nettype wire
